// ---- include/lsa_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef LSA_MAP_SVH
`define LSA_MAP_SVH

`define LSA_NUM_LOC 5
`define LSA_ADDR_TOP 8
`define LSA_LOC_ENGINE 3'h5
`define LSA_OFS_ACCESS 5'h00
`define LSA_OFS_STATUS 5'h04
`define LSA_OFS_ENGINE 5'h00

`define LSA_ACC_EST 0
`define LSA_ACC_REQ 1
`define LSA_ACC_PEND 2
`define LSA_ACC_ACT 5
`define LSA_ACC_VALID 7

`define LSA_STS_EXPECT 3
`define LSA_STS_RESP 4
`define LSA_STS_GO 5
`define LSA_STS_READY 6
`define LSA_STS_VALID 7
`define LSA_STS_CANCEL 24
`define LSA_STS_LRESET 25
`define LSA_STS_WMASK 32'h03000068

`define LSA_ENG_MEASURE_END 0
`define LSA_ENG_BYTE_IN 1
`define LSA_ENG_EXEC_DONE 2
`define LSA_ENG_DRAINED 3

`define LSA_RST_EST 1'b0
`define LSA_NV_SETTLE_NS 100
`define LSA_CLK_NS 25
`define LSA_NV_SETTLE_CYC (((`LSA_NV_SETTLE_NS) + (`LSA_CLK_NS) - 1) / (`LSA_CLK_NS))

`endif

// ---- include/lsa_pkg.sv ----
// shared types of the locality arbiter and status block
package lsa_pkg;

    typedef enum logic [2:0] {
        LSA_CS_IDLE = 3'b000,
        LSA_CS_READY = 3'b001,
        LSA_CS_RECEPTION = 3'b010,
        LSA_CS_EXECUTION = 3'b011,
        LSA_CS_COMPLETION = 3'b100
    } lsa_cmd_state_e;

    typedef struct packed {
        logic wr;
        logic [2:0] loc;
        logic [4:0] ofs;
        logic [31:0] data;
    } lsa_acc_s;

endpackage : lsa_pkg

// ---- src/lsa_apb_slave.sv ----
// apb slave front end: one wait state, registered answer, write commit strobe
`timescale 1ns/1ps
module lsa_apb_slave import lsa_pkg::*; (
    input wire logic clk, // device clock
    input wire logic reset, // synchronous, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] rd_data, // read value for current address
    input wire logic rd_err, // current address unmapped
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error
    output lsa_acc_s acc // committed write, one cycle
);
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    wire access_ph = psel & penable;
    // the first access cycle samples the answer, the second completes it
    wire first_ph = access_ph & ~pready_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= first_ph;
            if (first_ph) begin
                prdata_q <= pwrite ? 32'h00000000 : rd_data;
                pslverr_q <= rd_err;
            end else if (!access_ph) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign acc.wr = access_ph & pready_q & pwrite & ~pslverr_q;
    assign acc.loc = paddr[7:5];
    assign acc.ofs = paddr[4:0];
    assign acc.data = pwdata;

endmodule : lsa_apb_slave

// ---- src/lsa_top.sv ----
// locality arbiter, launch flag and command state machine behind apb
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "lsa_map.svh"
module lsa_top import lsa_pkg::*; (
    input wire logic clk, // 40 mhz device clock
    input wire logic reset, // synchronous, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error
    input wire logic launch_nv_n, // stored launch flag from nv cell
    output logic launch_nv_wr, // one-cycle write strobe to nv cell
    output logic launch_nv_data, // value to store in nv cell
    output logic queue_flush, // one-cycle pulse, free both byte queues
    output logic cmd_abort, // one-cycle pulse, abort running command
    output logic cmd_start // one-cycle pulse, start execution
);
    lsa_acc_s acc;
    logic [4:0] req_q, req_d;
    logic [4:0] pend_q, pend_d;
    logic own_vld_q;
    logic [2:0] own_q;
    lsa_cmd_state_e cs_q, cs_d;
    logic resp_q;
    logic est_q;
    logic valid_q;
    logic [2:0] nv_sync_q;
    logic [3:0] settle_q;
    logic nv_wr_q, nv_data_q, flush_q, abort_q, start_q;
    logic [31:0] rd_data;
    logic rd_err;

    lsa_apb_slave u_apb (
        .clk(clk),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .rd_data(rd_data),
        .rd_err(rd_err),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .acc(acc)
    );

    // locality taken from the register copy being written
    wire [2:0] wl = acc.loc;
    wire loc_ok = wl < 3'(`LSA_NUM_LOC);
    wire [4:0] lbit = loc_ok ? (5'h01 << wl) : 5'h00;
    wire is_acc = acc.wr && loc_ok && acc.ofs == `LSA_OFS_ACCESS;
    wire is_sts = acc.wr && loc_ok && acc.ofs == `LSA_OFS_STATUS;
    wire is_eng = acc.wr && wl == `LSA_LOC_ENGINE && acc.ofs == `LSA_OFS_ENGINE;
    wire is_owner = own_vld_q && own_q == wl;
    wire has_req = |(req_q & lbit);

    // pending field bit is never looked at on a write
    wire req_wr = is_acc && acc.data[`LSA_ACC_REQ];
    wire act_wr = is_acc && acc.data[`LSA_ACC_ACT];
    wire do_request = req_wr && !is_owner && !has_req;
    wire do_relinq = act_wr && is_owner;
    wire do_cancel = act_wr && !is_owner && has_req;
    wire [4:0] rem = req_q & ~lbit;
    wire [2:0] rem_cnt = 3'($countones(rem));

    // highest locality number has highest priority
    function automatic logic [2:0] hi_idx(input logic [4:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < `LSA_NUM_LOC; i++) begin
            if (v[i]) r = 3'(i);
        end
        return r;
    endfunction : hi_idx

    wire grant_v = !own_vld_q && |req_q;
    wire [2:0] gidx = hi_idx(req_q);
    wire [4:0] gbit = grant_v ? (5'h01 << gidx) : 5'h00;
    wire loc_change = grant_v || do_relinq;

    always_comb begin
        req_d = req_q & ~gbit;
        if (do_cancel) req_d = req_d & ~lbit;
        if (do_request) req_d = req_d | lbit;
    end

    always_comb begin
        pend_d = pend_q;
        if (grant_v && (req_q & ~gbit & ~(do_cancel ? lbit : 5'h00)) == 5'h00) begin
            pend_d = 5'h00;
        end
        if (do_cancel) begin
            if (rem_cnt == 3'h0) begin
                pend_d = 5'h00;
            end else if (rem_cnt == 3'h1) begin
                pend_d = pend_d & ~rem;
            end
        end
        // two or more left: marks stay as they are
        if (do_request) pend_d = pend_d | ~lbit;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            req_q <= 5'h00;
            pend_q <= 5'h00;
            own_vld_q <= 1'b0;
            own_q <= 3'h0;
        end else begin
            req_q <= req_d;
            pend_q <= pend_d;
            if (grant_v) begin
                own_vld_q <= 1'b1;
                own_q <= gidx;
            end else if (do_relinq) begin
                own_vld_q <= 1'b0;
            end
        end
    end

    // status writes carry exactly one command field, otherwise dropped
    wire [31:0] sts_f = acc.data & `LSA_STS_WMASK;
    wire sts_one = is_sts && $onehot(sts_f);
    wire ready_wr = sts_one && is_owner && sts_f[`LSA_STS_READY];
    wire go_wr = sts_one && is_owner && sts_f[`LSA_STS_GO];
    wire cancel_wr = sts_one && is_owner && sts_f[`LSA_STS_CANCEL];
    wire lreset_wr = sts_one && sts_f[`LSA_STS_LRESET] && (wl == 3'h3 || wl == 3'h4);
    wire byte_in = is_eng && acc.data[`LSA_ENG_BYTE_IN];
    wire exec_done = is_eng && acc.data[`LSA_ENG_EXEC_DONE];
    wire drained = is_eng && acc.data[`LSA_ENG_DRAINED];
    wire measure_end = is_eng && acc.data[`LSA_ENG_MEASURE_END];

    always_comb begin
        cs_d = cs_q;
        unique case (cs_q)
            LSA_CS_IDLE: if (ready_wr) cs_d = LSA_CS_READY;
            LSA_CS_READY: if (byte_in) cs_d = LSA_CS_RECEPTION;
            LSA_CS_RECEPTION: begin
                if (go_wr) cs_d = LSA_CS_EXECUTION;
                else if (ready_wr) cs_d = LSA_CS_READY;
            end
            LSA_CS_EXECUTION: begin
                if (ready_wr || cancel_wr) cs_d = LSA_CS_IDLE;
                else if (exec_done) cs_d = LSA_CS_COMPLETION;
            end
            // one write both frees resources and makes ready
            LSA_CS_COMPLETION: if (ready_wr) cs_d = LSA_CS_READY;
            default: cs_d = LSA_CS_IDLE;
        endcase
        if (loc_change) cs_d = LSA_CS_IDLE;
    end

    wire leave_exec = cs_q == LSA_CS_EXECUTION && cs_d == LSA_CS_IDLE;
    wire free_now = (cs_q == LSA_CS_COMPLETION && ready_wr) || leave_exec;

    always_ff @(posedge clk) begin
        if (reset) begin
            cs_q <= LSA_CS_IDLE;
            resp_q <= 1'b0;
            flush_q <= 1'b0;
            abort_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            cs_q <= cs_d;
            flush_q <= free_now;
            abort_q <= leave_exec;
            start_q <= cs_q == LSA_CS_RECEPTION && cs_d == LSA_CS_EXECUTION;
            if (cs_q == LSA_CS_EXECUTION && cs_d == LSA_CS_COMPLETION) begin
                resp_q <= 1'b1;
            end else if (drained || cs_d != LSA_CS_COMPLETION) begin
                resp_q <= 1'b0;
            end
        end
    end

    // nv cell pin crosses in through three flops; 2nd and 3rd must agree
    wire nv_agree = nv_sync_q[1] == nv_sync_q[2];
    wire settle_done = settle_q == 4'(`LSA_NV_SETTLE_CYC);

    // flag reads zero until loaded so a false one is never shown
    always_ff @(posedge clk) begin
        if (reset) begin
            nv_sync_q <= 3'h0;
            settle_q <= 4'h0;
            valid_q <= 1'b0;
            est_q <= `LSA_RST_EST;
            nv_wr_q <= 1'b0;
            nv_data_q <= 1'b0;
        end else begin
            nv_sync_q <= {nv_sync_q[1:0], launch_nv_n};
            nv_wr_q <= 1'b0;
            if (!valid_q) begin
                if (!nv_agree) begin
                    settle_q <= 4'h0;
                end else if (!settle_done) begin
                    settle_q <= settle_q + 4'h1;
                end else begin
                    est_q <= nv_sync_q[2];
                    valid_q <= 1'b1;
                end
            end else if (lreset_wr && !est_q) begin
                est_q <= 1'b1;
                nv_wr_q <= 1'b1;
                nv_data_q <= 1'b1;
            end else if (measure_end && est_q) begin
                est_q <= 1'b0;
                nv_wr_q <= 1'b1;
                nv_data_q <= 1'b0;
            end
        end
    end

    // read side: locality taken from the address on the bus
    wire [2:0] rl = paddr[7:5];
    wire [4:0] rofs = paddr[4:0];
    wire r_loc_ok = rl < 3'(`LSA_NUM_LOC);
    wire r_hi_zero = paddr[31:`LSA_ADDR_TOP] == 24'h000000;
    wire r_acc = r_hi_zero && r_loc_ok && rofs == `LSA_OFS_ACCESS;
    wire r_sts = r_hi_zero && r_loc_ok && rofs == `LSA_OFS_STATUS;
    wire r_eng = r_hi_zero && rl == `LSA_LOC_ENGINE && rofs == `LSA_OFS_ENGINE;
    wire r_owner = own_vld_q && own_q == rl;
    wire est_rd = valid_q & est_q;
    wire r_pend = r_loc_ok && pend_q[rl];
    wire r_req = r_loc_ok && req_q[rl];

    wire [31:0] acc_word = (32'(valid_q) << `LSA_ACC_VALID)
        | (32'(r_owner) << `LSA_ACC_ACT)
        | (32'(r_pend) << `LSA_ACC_PEND)
        | (32'(r_req) << `LSA_ACC_REQ)
        | (32'(est_rd) << `LSA_ACC_EST);
    wire [31:0] sts_word = (32'(valid_q) << `LSA_STS_VALID)
        | (32'(cs_q == LSA_CS_READY) << `LSA_STS_READY)
        | (32'(resp_q) << `LSA_STS_RESP)
        | (32'(cs_q == LSA_CS_RECEPTION) << `LSA_STS_EXPECT);
    wire [31:0] eng_word = {29'h00000000, cs_q};

    assign rd_data = r_acc ? acc_word : (r_sts ? sts_word : (r_eng ? eng_word : 32'h00000000));
    assign rd_err = !(r_acc || r_sts || r_eng);

    assign launch_nv_wr = nv_wr_q;
    assign launch_nv_data = nv_data_q;
    assign queue_flush = flush_q;
    assign cmd_abort = abort_q;
    assign cmd_start = start_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_reception;
        cs_q == LSA_CS_RECEPTION && go_wr && !loc_change;
    endsequence

    // start pulse is registered on the same edge that enters execution
    sequence s_executing;
        (cs_q == LSA_CS_EXECUTION && start_q) ##1 !start_q;
    endsequence

    chk_request_pend: assert property (do_request |=> (pend_q | $past(lbit)) == 5'h1f)
        else $error("request did not mark other localities pending");
    chk_grant_clear: assert property (grant_v && req_q == gbit && !do_request
        |=> pend_q == 5'h00 && own_vld_q)
        else $error("grant with no requests left kept pending marks");
    chk_cancel_none: assert property (do_cancel && rem_cnt == 3'h0 |=> pend_q == 5'h00)
        else $error("cancel with none left kept pending marks");
    chk_cancel_one: assert property (do_cancel && rem_cnt == 3'h1
        |=> (pend_q & $past(rem)) == 5'h00)
        else $error("cancel with one left kept its pending mark");
    chk_cancel_many: assert property (do_cancel && rem_cnt > 3'h1 && !grant_v
        |=> pend_q == $past(pend_q))
        else $error("cancel with several left changed pending marks");
    chk_req_set: assert property (do_request |=> (req_q & $past(lbit)) != 5'h00)
        else $error("request flag not set");
    chk_grant_req: assert property (grant_v |=> (req_q & $past(gbit)) == 5'h00
        && own_q == $past(gidx))
        else $error("grant left request flag set");
    chk_zero_req: assert property (is_acc && !acc.data[`LSA_ACC_REQ] && !do_cancel && !grant_v
        |=> req_q == $past(req_q))
        else $error("zero write changed request flags");
    chk_free_grant: assert property (!own_vld_q && req_q != 5'h00 |=> own_vld_q)
        else $error("free device did not grant");
    chk_relinq_pass: assert property (do_relinq && rem != 5'h00
        |=> ##1 own_vld_q && own_q == $past(hi_idx(rem), 2))
        else $error("ownership not passed to highest waiting locality");
    chk_est_invalid: assert property ($rose(valid_q) |-> est_q == $past(nv_sync_q[2]))
        else $error("launch flag loaded with a value other than the stored one");
    chk_est_hold: assert property (valid_q && !est_q && !lreset_wr |=> !est_q)
        else $error("launch flag left zero without reset write");
    chk_est_clear: assert property (valid_q && est_q && measure_end && !lreset_wr
        |=> !est_q ##0 launch_nv_wr && !launch_nv_data)
        else $error("measure end did not clear launch flag");
    chk_est_reset: assert property (valid_q && !est_q && is_sts && acc.data == 32'h02000000
        && wl < 3'h3 |=> !est_q)
        else $error("launch reset honoured from low locality");
    chk_multi_drop: assert property (is_sts && !$onehot(sts_f) && sts_f != 32'h0
        && !loc_change && !is_eng |=> cs_q == $past(cs_q))
        else $error("multi-field status write acted");
    chk_abort_idle: assert property (cs_q == LSA_CS_EXECUTION && ready_wr
        |=> cs_q == LSA_CS_IDLE && cmd_abort && queue_flush)
        else $error("ready write did not abort execution");
    chk_go_exec: assert property (s_reception |=> s_executing)
        else $error("execute trigger did not start execution");
    chk_done_ready: assert property (cs_q == LSA_CS_COMPLETION && ready_wr && !loc_change
        |=> cs_q == LSA_CS_READY && queue_flush && !resp_q)
        else $error("completion ready write did not free and ready");

endmodule : lsa_top

// ---- test/lsa_nv_cell.sv ----
// behavioural non-volatile cell that keeps the launch flag across resets
`timescale 1ns/1ps
module lsa_nv_cell (
    input wire logic clk, // device clock
    input wire logic wr, // store strobe from the block
    input wire logic data, // value to store
    output logic stored_n // held value, 1 means never launched
);
    // powers up as never launched, has no reset of its own
    logic cell_q = 1'b1;
    always @(posedge clk) begin
        if (wr === 1'b1) begin
            cell_q <= data;
        end
    end
    assign stored_n = cell_q;
endmodule : lsa_nv_cell

// ---- test/locality_arbiter_status_fsm_tb.sv ----
// self-checking bench: arbitration, launch flag, command states over apb
`timescale 1ns/1ps
`include "lsa_map.svh"
module locality_arbiter_status_fsm_tb import lsa_pkg::*; ;
    localparam logic [31:0] ENG = 32'h000000a0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, launch_nv_n, launch_nv_wr, launch_nv_data;
    logic queue_flush, cmd_abort, cmd_start;
    logic [31:0] prdata;
    logic [31:0] lfsr_q = 32'h9d5176ca;
    logic [4:0] req = 5'h0;
    logic [4:0] pend = 5'h0;
    logic est = 1'b1;
    int owner = -1;
    int error_cnt = 0;
    int n_compared = 0;
    int n_start = 0;
    int n_abort = 0;
    int n_flush = 0;

    lsa_top uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .launch_nv_n(launch_nv_n), .launch_nv_wr(launch_nv_wr),
        .launch_nv_data(launch_nv_data), .queue_flush(queue_flush), .cmd_abort(cmd_abort),
        .cmd_start(cmd_start));
    lsa_nv_cell u_nv (.clk(clk), .wr(launch_nv_wr), .data(launch_nv_data),
        .stored_n(launch_nv_n));

    always #12.5 clk = ~clk;

    // pulses last one cycle, so count them at every edge
    always @(posedge clk) begin
        if (cmd_start === 1'b1) n_start <= n_start + 1;
        if (cmd_abort === 1'b1) n_abort <= n_abort + 1;
        if (queue_flush === 1'b1) n_flush <= n_flush + 1;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [31:0] acc_a(input int l);
        return l * 32'h20 + `LSA_OFS_ACCESS;
    endfunction : acc_a

    function automatic logic [31:0] sts_a(input int l);
        return l * 32'h20 + `LSA_OFS_STATUS;
    endfunction : sts_a

    function automatic logic [31:0] acc_exp(input int l);
        logic [31:0] w;
        w = 32'h0;
        w[`LSA_ACC_EST] = est;
        w[`LSA_ACC_REQ] = req[l];
        w[`LSA_ACC_PEND] = pend[l];
        w[`LSA_ACC_ACT] = (owner == l);
        w[`LSA_ACC_VALID] = 1'b1;
        return w;
    endfunction : acc_exp

    function automatic logic exp_err(input logic [31:0] a);
        return !(a[31:8] == 24'h0 && (a[7:0] == 8'ha0 ||
            (a[7:0] < 8'ha0 && (a[4:0] == 5'h00 || a[4:0] == 5'h04))));
    endfunction : exp_err

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held from setup until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        logic done;
        done = 1'b0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        chk("pready in setup", 32'h0, {31'h0, pready});
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        while (!done) begin
            @(posedge clk);
            done = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x,
        input string what);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk(what, x, d & m);
    endtask : rd_chk

    task automatic chk_all();
        for (int l = 0; l < 5; l++) rd_chk(acc_a(l), 32'hffffffff, acc_exp(l), "access view");
    endtask : chk_all

    task automatic step(input logic [31:0] a, input logic [31:0] v, input logic [2:0] s);
        wr(a, v);
        rd_chk(ENG, 32'h7, {29'h0, s}, "cmd state");
    endtask : step

    // highest-numbered requester wins a free device
    task automatic grant();
        for (int k = 4; k >= 0; k--) begin
            if (owner < 0 && req[k]) begin
                owner = k;
                req[k] = 1'b0;
            end
        end
        if (req == 5'h0) pend = 5'h0;
    endtask : grant

    task automatic do_req(input int l);
        wr(acc_a(l), 32'h1 << `LSA_ACC_REQ);
        if (owner != l && !req[l]) begin
            req[l] = 1'b1;
            pend = pend | ~(5'h1 << l);
        end
        if (owner < 0) grant();
    endtask : do_req

    task automatic do_act(input int l);
        wr(acc_a(l), 32'h1 << `LSA_ACC_ACT);
        if (owner == l) begin
            owner = -1;
            grant();
        end else if (req[l]) begin
            req[l] = 1'b0;
            if ($countones(req) == 0) pend = 5'h0;
            else if ($countones(req) == 1) pend = pend & ~req;
        end
    endtask : do_act

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        logic [31:0] d;
        logic [31:0] q;
        logic e;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd_chk(acc_a(0), 32'h81, 32'h0, "unsettled view");
        repeat (12) @(posedge clk);
        chk_all();
        do_req(0);
        chk_all();
        do_req(1);
        do_req(3);
        do_req(3);
        chk_all();
        wr(acc_a(3), 32'h0);
        wr(acc_a(2), 32'h1 << `LSA_ACC_PEND);
        chk_all();
        do_act(1);
        chk_all();
        do_req(2);
        do_req(4);
        do_act(2);
        chk_all();
        do_act(0);
        chk_all();
        do_act(3);
        chk_all();
        do_act(4);
        do_req(1);
        chk_all();
        step(sts_a(1), 32'h40, 3'h1);
        step(ENG, 32'h2, 3'h2);
        step(sts_a(1), 32'h60, 3'h2);
        step(sts_a(1), 32'h0, 3'h2);
        step(sts_a(1), 32'h20, 3'h3);
        step(sts_a(1), 32'h40, 3'h0);
        step(sts_a(1), 32'h40, 3'h1);
        step(ENG, 32'h2, 3'h2);
        step(sts_a(1), 32'h20, 3'h3);
        step(ENG, 32'h4, 3'h4);
        rd_chk(sts_a(1), 32'h10, 32'h10, "response available");
        step(ENG, 32'h8, 3'h4);
        rd_chk(sts_a(1), 32'h10, 32'h0, "response available");
        // one ready write after completion frees queues and readies
        step(sts_a(1), 32'h40, 3'h1);
        chk("start pulses", 32'd2, n_start);
        chk("abort pulses", 32'd1, n_abort);
        chk("flush pulses", 32'd2, n_flush);
        for (int i = 0; i < 12; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            step(sts_a(i % 4 == 1 ? 4 : i % 4), lfsr_q, 3'h1);
        end
        for (int i = 0; i < 24; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            d = {23'h0, lfsr_q[31] & lfsr_q[30], lfsr_q[7:2], 2'b00};
            apb(1'b0, d, 32'h0, q, e);
            chk("slave error", {31'h0, exp_err(d)}, {31'h0, e});
            if (e) chk("error read data", 32'h0, q);
        end
        wr(ENG, 32'h1);
        est = 1'b0;
        chk_all();
        wr(sts_a(1), 32'h1 << `LSA_STS_LRESET);
        chk_all();
        reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        owner = -1;
        req = 5'h0;
        pend = 5'h0;
        @(posedge clk);
        rd_chk(acc_a(2), 32'h81, 32'h0, "unsettled view");
        repeat (12) @(posedge clk);
        chk_all();
        wr(sts_a(3), 32'h1 << `LSA_STS_LRESET);
        est = 1'b1;
        chk_all();
        end_sim();
    end
endmodule : locality_arbiter_status_fsm_tb
